// >>> pcr_link.sv
// Purpose: run-command decode, status dead-time and echo signaling
// Assumes: line sampled through two flops; pull-up is off chip
// Notes: AXI4-Lite slave holds presets, thresholds and diagnostics
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - burst-listen: burst preset pulses at its limit, then record.
// RULE2 - listen-only: no burst, record with preset length and thresholds.
// RULE3 - status returned by lengthening dead-time up to three units.
// RULE4 - crc adds three units, else diag two, else uninit one.
// RULE5 - no active error means base dead-time only.
// RULE6 - uninit flag set with no threshold group; commands ignored.
// RULE7 - diag flag on frequency deviation beyond the delta.
// RULE8 - diag flag on excitation voltage below the level.
// RULE9 - crc flag refuses every run command while set.
// RULE10 - any nonvolatile register write clears the crc flag.
// RULE11 - during record pull line low while echo exceeds threshold.
// RULE12 - at record end release line and accept commands.
// RULE13 - hold line low for the burst, then release.
// RULE14 - after dead-time force line low at least 300 us.
// RULE15 - controller computes distance from edges and burst length.
// RULE16 - controller rejects spurious hit just after the 300 us mark.
// RULE17 - line idles high; command chosen by low duration.
// RULE18 - line stuck over 15 ms during a command resets comms.
// RULE19 - dead-time after each command before driving the line.
// RULE20 - undervoltage lets a command finish, blocks new ones.
module pcr_link (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe_n_o,
	output logic burst_o,
	output logic [7:0] current_limit_o,
	output logic preset_b_o,
	input wire logic [7:0] echo_i,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// registers
	logic [31:0] preset_a_ff, nxt_preset_a;
	logic [31:0] preset_b_ff, nxt_preset_b;
	logic [31:0] diag_ff, nxt_diag;
	logic [31:0] thr_a_ff, nxt_thr_a;
	logic [31:0] thr_b_ff, nxt_thr_b;
	logic thr_a_init_ff, nxt_thr_a_init;
	logic thr_b_init_ff, nxt_thr_b_init;
	logic crc_ff, nxt_crc;
	logic uv_ff, nxt_uv;
	// bus handshake state
	logic aw_got_ff, nxt_aw_got;
	logic w_got_ff, nxt_w_got;
	logic [7:0] aw_ff, nxt_aw;
	logic [31:0] wd_ff, nxt_wd;
	logic [3:0] ws_ff, nxt_ws;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	// link state
	pcr_pkg::pcr_state_e st_ff, nxt_st;
	logic [19:0] cnt_ff, nxt_cnt;
	logic [19:0] stuck_ff, nxt_stuck;
	logic [19:0] dead_ff, nxt_dead;
	logic [7:0] pulses_ff, nxt_pulses;
	logic sel_b_ff, nxt_sel_b;
	logic listen_ff, nxt_listen;
	logic line_ff, nxt_line;
	logic burst_ff, nxt_burst;
	logic [7:0] ilim_ff, nxt_ilim;
	logic volt_err_ff, nxt_volt_err;
	logic sync1_ff, sync2_ff, prev_ff;
	logic diag_flag;
	logic [1:0] units;

	// line synchroniser, then edge history
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			sync1_ff <= line_i;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// diagnostic compare on live measurements
	always_comb begin
		logic [7:0] meas, nom, dif;
		meas = diag_ff[pcr_pkg::FREQ_MEAS_LSB +: 8];
		nom = diag_ff[pcr_pkg::FREQ_NOM_LSB +: 8];
		dif = (meas > nom) ? meas - nom : nom - meas;
		// RULE7 frequency deviation
		diag_flag = dif > diag_ff[pcr_pkg::FREQ_DELTA_LSB +: 8];
		// RULE8 low excitation seen on the last burst
		if (volt_err_ff) begin
			diag_flag = 1'b1;
		end
	end

	pcr_stat_enc u_enc (
		.uninit_i(!(thr_a_init_ff || thr_b_init_ff)),
		.diag_i(diag_flag),
		.crc_i(crc_ff),
		.units_o(units)
	);

	// AXI4-Lite slave: address and data taken in either order
	always_comb begin
		logic do_wr;
		logic [31:0] wv;
		do_wr = 1'b0;
		wv = 32'h0000_0000;
		nxt_aw_got = aw_got_ff;
		nxt_w_got = w_got_ff;
		nxt_aw = aw_ff;
		nxt_wd = wd_ff;
		nxt_ws = ws_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_preset_a = preset_a_ff;
		nxt_preset_b = preset_b_ff;
		nxt_diag = diag_ff;
		nxt_thr_a = thr_a_ff;
		nxt_thr_b = thr_b_ff;
		nxt_thr_a_init = thr_a_init_ff;
		nxt_thr_b_init = thr_b_init_ff;
		nxt_crc = crc_ff;
		nxt_uv = uv_ff;
		if (s_axi_awvalid && !aw_got_ff) begin
			nxt_aw_got = 1'b1;
			nxt_aw = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !w_got_ff) begin
			nxt_w_got = 1'b1;
			nxt_wd = s_axi_wdata;
			nxt_ws = s_axi_wstrb;
		end
		if (aw_got_ff && w_got_ff && !bvalid_ff) begin
			do_wr = 1'b1;
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = 2'b00;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (do_wr) begin
			unique case (aw_ff)
			pcr_pkg::CTRL_OFS: begin
				wv = merge(32'h0000_0000, wd_ff, ws_ff);
				nxt_uv = wv[pcr_pkg::CTL_UV_BIT];
				if (wv[pcr_pkg::CTL_CRC_SET_BIT]) begin
					nxt_crc = 1'b1;
				end
			end
			pcr_pkg::PRESET_A_OFS: begin
				nxt_preset_a = merge(preset_a_ff, wd_ff, ws_ff);
				// RULE10 nvm write clears crc
				nxt_crc = 1'b0;
			end
			pcr_pkg::PRESET_B_OFS: begin
				nxt_preset_b = merge(preset_b_ff, wd_ff, ws_ff);
				nxt_crc = 1'b0;
			end
			pcr_pkg::DIAG_OFS: begin
				nxt_diag = merge(diag_ff, wd_ff, ws_ff);
				nxt_crc = 1'b0;
			end
			pcr_pkg::THR_A_OFS: begin
				nxt_thr_a = merge(thr_a_ff, wd_ff, ws_ff);
				// RULE6 group now initialised
				nxt_thr_a_init = 1'b1;
			end
			pcr_pkg::THR_B_OFS: begin
				nxt_thr_b = merge(thr_b_ff, wd_ff, ws_ff);
				nxt_thr_b_init = 1'b1;
			end
			default: begin
				nxt_bresp = 2'b10; // unmapped or read-only: slave error
			end
			endcase
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = 2'b00;
			unique case (s_axi_araddr[7:0])
			pcr_pkg::CTRL_OFS: nxt_rdata = {30'd0, uv_ff, 1'b0};
			pcr_pkg::PRESET_A_OFS: nxt_rdata = preset_a_ff;
			pcr_pkg::PRESET_B_OFS: nxt_rdata = preset_b_ff;
			pcr_pkg::DIAG_OFS: nxt_rdata = diag_ff;
			pcr_pkg::STATUS_OFS: nxt_rdata = {27'd0,
				st_ff != pcr_pkg::PCR_IDLE, uv_ff, crc_ff, diag_flag,
				!(thr_a_init_ff || thr_b_init_ff)};
			pcr_pkg::THR_A_OFS: nxt_rdata = thr_a_ff;
			pcr_pkg::THR_B_OFS: nxt_rdata = thr_b_ff;
			pcr_pkg::ECHO_OFS: nxt_rdata = {24'd0, echo_i};
			default: begin
				nxt_rdata = 32'h0000_0000;
				nxt_rresp = 2'b10;
			end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// link sequencer
	always_comb begin
		logic [31:0] pre;
		logic [7:0] thr;
		logic [19:0] low;
		pre = sel_b_ff ? preset_b_ff : preset_a_ff;
		thr = sel_b_ff ? thr_b_ff[7:0] : thr_a_ff[7:0];
		low = cnt_ff;
		nxt_st = st_ff;
		nxt_cnt = cnt_ff + 20'd1;
		nxt_stuck = 20'd0;
		nxt_dead = dead_ff;
		nxt_pulses = pulses_ff;
		nxt_sel_b = sel_b_ff;
		nxt_listen = listen_ff;
		nxt_line = 1'b1;
		nxt_burst = 1'b0;
		nxt_ilim = ilim_ff;
		nxt_volt_err = volt_err_ff;
		unique case (st_ff)
		pcr_pkg::PCR_IDLE: begin
			// RULE17 falling edge opens a command
			if (prev_ff && !sync2_ff) begin
				nxt_st = pcr_pkg::PCR_CMD;
				nxt_cnt = 20'd0;
			end
		end
		pcr_pkg::PCR_CMD: begin
			nxt_stuck = stuck_ff + 20'd1;
			if (sync2_ff) begin
				nxt_st = pcr_pkg::PCR_IDLE;
				nxt_cnt = 20'd0;
				// RULE19 base dead-time plus status units
				// RULE3 extension encodes status
				nxt_dead = 20'(pcr_pkg::DEAD_CYC) * (20'd1 + 20'(units));
				if (low >= 20'(pcr_pkg::CMD_BLA_CYC) &&
					low < 20'(pcr_pkg::CMD_MAX_CYC) &&
					// RULE6 refuses run commands until a group is written; crc and uv (RULE9 RULE20) refuse them in every case
					thr_a_init_ff | thr_b_init_ff && !crc_ff && !uv_ff) begin
					nxt_st = pcr_pkg::PCR_DEAD;
					nxt_sel_b = (low >= 20'(pcr_pkg::CMD_BLB_CYC) &&
						low < 20'(pcr_pkg::CMD_LOA_CYC)) ||
						low >= 20'(pcr_pkg::CMD_LOB_CYC);
					nxt_listen = low >= 20'(pcr_pkg::CMD_LOA_CYC);
				end
			end else if (stuck_ff >= 20'(pcr_pkg::STUCK_CYC)) begin
				// RULE18 stuck line resets comms
				nxt_st = pcr_pkg::PCR_IDLE;
			end
		end
		pcr_pkg::PCR_DEAD: begin
			if (cnt_ff + 20'd1 >= dead_ff) begin
				nxt_cnt = 20'd0;
				nxt_pulses = 8'd0;
				nxt_ilim = pre[pcr_pkg::CURR_LSB +: 8];
				// a burst starts a fresh voltage measurement
				nxt_volt_err = volt_err_ff && listen_ff;
				// RULE1 RULE2 burst or listen only
				nxt_st = listen_ff ? pcr_pkg::PCR_MARK : pcr_pkg::PCR_BURST;
			end
		end
		pcr_pkg::PCR_BURST: begin
			// RULE13 line low for burst
			nxt_line = 1'b0;
			nxt_burst = cnt_ff < 20'(pcr_pkg::PULSE_CYC / 2);
			if (cnt_ff + 20'd1 >= 20'(pcr_pkg::PULSE_CYC)) begin
				nxt_cnt = 20'd0;
				nxt_pulses = pulses_ff + 8'd1;
				if (pulses_ff + 8'd1 >= pre[pcr_pkg::PULSE_LSB +: 8]) begin
					nxt_st = pcr_pkg::PCR_MARK;
				end
			end
		end
		pcr_pkg::PCR_MARK: begin
			// RULE14 minimum record mark
			nxt_line = 1'b0;
			if (cnt_ff + 20'd1 >= 20'(pcr_pkg::MIN_LOW_CYC)) begin
				nxt_cnt = 20'd0;
				nxt_pulses = 8'd0;
				nxt_st = pcr_pkg::PCR_REC;
			end
		end
		pcr_pkg::PCR_REC: begin
			// RULE11 echo over threshold pulls low
			nxt_line = !(echo_i > thr);
			if (cnt_ff + 20'd1 >= 20'(pcr_pkg::REC_UNIT_CYC)) begin
				nxt_cnt = 20'd0;
				nxt_pulses = pulses_ff + 8'd1;
				// RULE12 record end releases line
				if (pulses_ff + 8'd1 >= pre[pcr_pkg::REC_LSB +: 8]) begin
					nxt_line = 1'b1;
					nxt_st = pcr_pkg::PCR_IDLE;
				end
			end
		end
		default: nxt_st = pcr_pkg::PCR_IDLE;
		endcase
		// RULE8 latched, since status units are taken after the burst
		if (burst_ff && echo_i < diag_ff[pcr_pkg::VOLT_LVL_LSB +: 8]) begin
			nxt_volt_err = 1'b1;
		end
	end

	// register all state except the line synchroniser
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			preset_a_ff <= pcr_pkg::PRESET_RST;
			preset_b_ff <= pcr_pkg::PRESET_RST;
			diag_ff <= pcr_pkg::DIAG_RST;
			thr_a_ff <= pcr_pkg::THR_RST;
			thr_b_ff <= pcr_pkg::THR_RST;
			thr_a_init_ff <= 1'b0;
			thr_b_init_ff <= 1'b0;
			crc_ff <= 1'b0;
			uv_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_ff <= 8'h00;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'b00;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'b00;
			st_ff <= pcr_pkg::PCR_IDLE;
			cnt_ff <= 20'd0;
			stuck_ff <= 20'd0;
			dead_ff <= 20'd0;
			pulses_ff <= 8'd0;
			sel_b_ff <= 1'b0;
			listen_ff <= 1'b0;
			line_ff <= 1'b1;
			burst_ff <= 1'b0;
			ilim_ff <= 8'h00;
			volt_err_ff <= 1'b0;
		end else begin
			preset_a_ff <= nxt_preset_a;
			preset_b_ff <= nxt_preset_b;
			diag_ff <= nxt_diag;
			thr_a_ff <= nxt_thr_a;
			thr_b_ff <= nxt_thr_b;
			thr_a_init_ff <= nxt_thr_a_init;
			thr_b_init_ff <= nxt_thr_b_init;
			crc_ff <= nxt_crc;
			uv_ff <= nxt_uv;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			aw_ff <= nxt_aw;
			wd_ff <= nxt_wd;
			ws_ff <= nxt_ws;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			stuck_ff <= nxt_stuck;
			dead_ff <= nxt_dead;
			pulses_ff <= nxt_pulses;
			sel_b_ff <= nxt_sel_b;
			listen_ff <= nxt_listen;
			line_ff <= nxt_line;
			burst_ff <= nxt_burst;
			ilim_ff <= nxt_ilim;
			volt_err_ff <= nxt_volt_err;
		end
	end

	// outputs straight from flops except line_o, tied low; line drive is open drain
	assign line_o = 1'b0;
	assign line_oe_n_o = line_ff;
	assign burst_o = burst_ff;
	assign current_limit_o = ilim_ff;
	assign preset_b_o = sel_b_ff;
	assign s_axi_awready = !aw_got_ff;
	assign s_axi_wready = !w_got_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

// >>> pcr_pkg.sv
// Purpose: shared constants and types for the run-command echo link
// Assumes: 40 MHz core clock, AXI4-Lite register access
// Notes: all timing counts derive from printed or chosen times
package pcr_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PRESET_A_OFS = 8'h04;
	localparam logic [7:0] PRESET_B_OFS = 8'h08;
	localparam logic [7:0] DIAG_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] THR_A_OFS = 8'h14;
	localparam logic [7:0] THR_B_OFS = 8'h18;
	localparam logic [7:0] ECHO_OFS = 8'h1C;
	// preset register fields
	localparam int PULSE_LSB = 0;
	localparam int CURR_LSB = 8;
	localparam int REC_LSB = 16;
	// diag register fields
	localparam int FREQ_MEAS_LSB = 0;
	localparam int FREQ_NOM_LSB = 8;
	localparam int FREQ_DELTA_LSB = 16;
	localparam int VOLT_LVL_LSB = 24;
	// status register bits
	localparam int ST_UNINIT_BIT = 0;
	localparam int ST_DIAG_BIT = 1;
	localparam int ST_CRC_BIT = 2;
	localparam int ST_UV_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	// ctrl register bits
	localparam int CTL_CRC_SET_BIT = 0;
	localparam int CTL_UV_BIT = 1;
	// reset values
	localparam logic [31:0] PRESET_RST = 32'h0000_0000;
	localparam logic [31:0] DIAG_RST = 32'h0000_0000;
	localparam logic [31:0] THR_RST = 32'h0000_0000;
	// timing in microseconds, stuck limit in milliseconds
	localparam int unsigned MIN_LOW_US = 300;
	localparam int unsigned STUCK_MS = 15;
	localparam int unsigned DEAD_US = 100;
	localparam int unsigned PULSE_US = 25;
	localparam int unsigned REC_UNIT_US = 1000;
	// command low windows in microseconds
	localparam int unsigned CMD_BLA_US = 200;
	localparam int unsigned CMD_BLB_US = 400;
	localparam int unsigned CMD_LOA_US = 600;
	localparam int unsigned CMD_LOB_US = 800;
	localparam int unsigned CMD_MAX_US = 1000;
	// cycle counts, each time multiplied by whole cycles per microsecond
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned MIN_LOW_CYC = MIN_LOW_US * CYC_PER_US;
	localparam int unsigned STUCK_CYC = STUCK_MS * 1000 * CYC_PER_US;
	localparam int unsigned DEAD_CYC = DEAD_US * CYC_PER_US;
	localparam int unsigned PULSE_CYC = PULSE_US * CYC_PER_US;
	localparam int unsigned REC_UNIT_CYC = REC_UNIT_US * CYC_PER_US;
	localparam int unsigned CMD_BLA_CYC = CMD_BLA_US * CYC_PER_US;
	localparam int unsigned CMD_BLB_CYC = CMD_BLB_US * CYC_PER_US;
	localparam int unsigned CMD_LOA_CYC = CMD_LOA_US * CYC_PER_US;
	localparam int unsigned CMD_LOB_CYC = CMD_LOB_US * CYC_PER_US;
	localparam int unsigned CMD_MAX_CYC = CMD_MAX_US * CYC_PER_US;
	typedef enum logic [2:0] {
		PCR_IDLE = 3'b000,
		PCR_CMD = 3'b001,
		PCR_DEAD = 3'b011,
		PCR_BURST = 3'b010,
		PCR_MARK = 3'b110,
		PCR_REC = 3'b111
	} pcr_state_e;
endpackage

// >>> pcr_stat_enc.sv
// Purpose: pick the status extension from the three status flags
// Assumes: flags are registered levels in the core clock domain
// Notes: pure combinational priority encoder
`timescale 1ns/100ps
`default_nettype none
module pcr_stat_enc (
	input wire logic uninit_i,
	input wire logic diag_i,
	input wire logic crc_i,
	output logic [1:0] units_o
);
	// highest priority flag wins
	always_comb begin
		// RULE4 strict priority
		if (crc_i) begin
			units_o = 2'd3;
		end else if (diag_i) begin
			units_o = 2'd2;
		end else if (uninit_i) begin
			units_o = 2'd1;
		end else begin
			// RULE5 no extension
			units_o = 2'd0;
		end
	end
endmodule
`default_nettype wire

// >>> pcr_link_properties.sv
// Purpose: port checks on the run-command link
// Assumes: one clock domain, synchronous active low reset
// Notes: helper counters stand in for long hold windows
`timescale 1ns/100ps
`default_nettype none
module pcr_link_chk (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic line_i,
	input wire logic line_o,
	input wire logic line_oe_n_o,
	input wire logic burst_o,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int MARK = pcr_pkg::MIN_LOW_CYC;
	localparam int DEAD = pcr_pkg::DEAD_CYC;
	logic [15:0] sb_ff, nxt_sb, sc_ff, nxt_sc;
	logic ln_ff, oe_ff;
	// cycles since burst drive and since the controller let go
	always_comb begin
		nxt_sb = (sb_ff == 16'hFFFF) ? sb_ff : sb_ff + 16'h0001;
		nxt_sc = (sc_ff == 16'hFFFF) ? sc_ff : sc_ff + 16'h0001;
		if (burst_o) nxt_sb = 16'h0000;
		// a rise while undriven can only be the command ending
		if (line_i && !ln_ff && oe_ff) nxt_sc = 16'h0000;
		if (!nrst_i) begin
			nxt_sb = 16'hFFFF;
			nxt_sc = 16'hFFFF;
		end
	end
	// helper registers
	always_ff @(posedge core_clk_i) begin
		sb_ff <= nxt_sb;
		sc_ff <= nxt_sc;
		ln_ff <= line_i;
		oe_ff <= line_oe_n_o;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	open_drain_a: assert property (line_o == 1'h0)
		else $error("line data not low");
	burst_low_a: assert property (burst_o |-> !line_oe_n_o)
		else $error("line released during burst");
	mark_hold_a: assert property (sb_ff < MARK |-> !line_oe_n_o)
		else $error("mark low too short");
	dead_quiet_a: assert property (sc_ff < DEAD |-> line_oe_n_o)
		else $error("line driven inside dead time");
	wr_resp_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	wr_refuse_a: assert property (aw_w_taken |=> !s_axi_awready)
		else $error("address taken twice");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rd_resp_a: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
endmodule
bind pcr_link pcr_link_chk u_chk (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .line_i(line_i),
	.line_o(line_o), .line_oe_n_o(line_oe_n_o), .burst_o(burst_o),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// >>> pcr_mcu.sv
// Purpose: controller model timing run commands on the line
// Assumes: line level is fed back with the pull-up applied
// Notes: levels are timed on the falling clock, where settled
`timescale 1ns/100ps
`default_nettype none
module pcr_mcu (
	input wire logic clk_i,
	input wire logic line_i,
	output logic pull_n_o
);
	// released at start, so the pull-up holds the line high
	initial pull_n_o = 1'h1;
	task automatic send(input int cyc);
		@(posedge clk_i);
		pull_n_o <= 1'h0;
		repeat (cyc) @(posedge clk_i);
		pull_n_o <= 1'h1;
		@(posedge clk_i);
	endtask
	// edge timing, bounded so a stuck line cannot hang
	task automatic meas(input logic lvl, input int lim, output int n);
		n = 0;
		@(negedge clk_i);
		while (line_i === lvl && n < lim) begin
			n++;
			@(negedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// >>> pulse_cmd_run_echo_signaling_tb.sv
// Purpose: self-checking bench for the run-command link
// Assumes: off-chip pull-up, controller model makes the lows
// Notes: a single 1 ms record keeps the run short
`timescale 1ns/100ps
`default_nettype none
module pulse_cmd_run_echo_signaling_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] br;
		logic [31:0] rd;
		logic [1:0] rr;
	} pcr_row_s;
	// just inside the first window, so each command costs little time
	localparam int CMD = pcr_pkg::CMD_BLA_CYC + 100;
	localparam int DT = 3 * pcr_pkg::DEAD_CYC;
	localparam int LOW = 2 * pcr_pkg::PULSE_CYC + pcr_pkg::MIN_LOW_CYC;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic [7:0] echo = 8'h00;
	logic [31:0] awaddr = 32'h0000_0000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] araddr = 32'h0000_0000;
	logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic pull_n, oe_n, lo, burst, preb, awr, wrd, bv, arr, rv;
	logic [7:0] clim;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, v;
	wire logic line_w;
	int errors = 0, cmp_count = 0, pulses = 0, n;
	pcr_row_s rows[5] = '{
		'{pcr_pkg::PRESET_A_OFS, 32'h0001_0502, 2'h0, 32'h0001_0502, 2'h0},
		'{pcr_pkg::PRESET_B_OFS, 32'h0002_0703, 2'h0, 32'h0002_0703, 2'h0},
		'{pcr_pkg::DIAG_OFS, 32'h0004_1010, 2'h0, 32'h0004_1010, 2'h0},
		'{pcr_pkg::STATUS_OFS, 32'h0000_00FF, 2'h2, 32'h0000_0001, 2'h0},
		'{8'h20, 32'h0000_0001, 2'h2, 32'h0000_0000, 2'h2}
	};
	// open-drain wire: anyone pulling wins over the pull-up
	assign line_w = pull_n & (oe_n | lo);
	always #12.5 core_clk = ~core_clk;
	always @(posedge burst) pulses++;
	pcr_link DUT (
		.core_clk_i(core_clk), .nrst_i(nrst), .line_i(line_w),
		.line_o(lo), .line_oe_n_o(oe_n), .burst_o(burst),
		.current_limit_o(clim), .preset_b_o(preb), .echo_i(echo),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rready)
	);
	pcr_mcu u_mcu (.clk_i(core_clk), .line_i(line_w), .pull_n_o(pull_n));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	// each channel released only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] rs);
		@(posedge core_clk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awr === 1'h1) awv <= 1'h0;
			if (wrd === 1'h1) wv <= 1'h0;
		end while (bv !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] rs);
		@(posedge core_clk);
		araddr <= {24'h00_0000, a};
		arv <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arr === 1'h1) arv <= 1'h0;
		end while (rv !== 1'h1);
		d = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	// echo level for a few cycles, line drive checked once settled
	task automatic probe(input logic [7:0] e, input int w, input logic x);
		repeat (w) @(posedge core_clk);
		echo <= e;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk({31'h0, oe_n}, {31'h0, x});
		@(posedge core_clk);
		echo <= 8'h00;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence: registers, refusals, one full run, then an undervoltage refusal
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({17'h0, oe_n, burst, clim, bv, rv, awr, wrd, arr},
			32'h0000_4007);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, r);
			chk({30'h0, r}, {30'h0, rows[i].br});
			rd(rows[i].a, v, r);
			chk(v, rows[i].rd);
			chk({30'h0, r}, {30'h0, rows[i].rr});
		end
		u_mcu.send(CMD);
		// a refused command leaves the line alone and the sequencer idle
		u_mcu.meas(1'h1, 20, n);
		chk(n, 20);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_0001);
		wr(pcr_pkg::THR_A_OFS, 32'h0000_0040, r);
		wr(pcr_pkg::CTRL_OFS, 32'h0000_0001, r);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_0004);
		u_mcu.send(CMD);
		u_mcu.meas(1'h1, 20, n);
		chk(n, 20);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_0004);
		wr(pcr_pkg::PRESET_A_OFS, 32'h0001_0502, r);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_0000);
		wr(pcr_pkg::DIAG_OFS, 32'h0004_1020, r);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_0002);
		pulses = 0;
		u_mcu.send(CMD);
		u_mcu.meas(1'h1, 20000, n);
		chk({31'h0, n >= DT && n <= DT + 8}, 32'h1);
		u_mcu.meas(1'h0, 20000, n);
		// the sample that ended the previous wait was already low
		chk({31'h0, n + 1 >= LOW && n + 1 <= LOW + 8}, 32'h1);
		chk(pulses, 2);
		chk({24'h0, clim}, 32'h0000_0005);
		chk({31'h0, preb}, 32'h0);
		probe(8'h41, 1000, 1'h0);
		probe(8'h40, 4, 1'h1);
		probe(8'h41, 38780, 1'h0);
		probe(8'h41, 400, 1'h1);
		// undervoltage flag alone must block the next command
		wr(pcr_pkg::CTRL_OFS, 32'h0000_0002, r);
		u_mcu.send(CMD);
		u_mcu.meas(1'h1, 20, n);
		chk(n, 20);
		rd(pcr_pkg::STATUS_OFS, v, r);
		chk(v, 32'h0000_000A);
		tally_and_finish();
	end
	// cut a hang just past the expected run length
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
